// ==== pkg/gram_write_map.vh ====
// register offsets, field positions, logic codes, limits and timing counts for the graphics write unit
`ifndef GRAM_WRITE_MAP_VH
`define GRAM_WRITE_MAP_VH

`define REG_ENTRY_MODE     12'h000
`define REG_WRITE_MASK     12'h004
`define REG_COMPARE        12'h008
`define REG_ADDR_SET       12'h00c
`define REG_RAM_DATA       12'h010
`define REG_ADDR_STATUS    12'h014
`define REG_DISPLAY_CTRL   12'h018
`define REG_SCAN_ADDR      12'h01c
`define REG_PALETTE_BASE   12'h100
`define REG_PALETTE_LAST   12'h17c

`define MODE_STEP_BIT      0
`define MODE_DIR_BIT       1
`define MODE_LOGIC_LO      2
`define MODE_LOGIC_HI      4
`define CTRL_DISP_ON_BIT   0
`define CTRL_EXT_CLK_BIT   1
`define CTRL_OSC_LO        4
`define CTRL_OSC_HI        7

`define LOGIC_PLAIN        3'h0
`define LOGIC_MATCH        3'h6
`define LOGIC_MISMATCH     3'h7

`define ROW_LAST           8'ha1
`define COL_LAST           8'h83
`define VERT_STEP          16'h0100
`define LEVEL_MAX          6'h34
`define PWM_PERIOD         6'h34

`endif

// ==== rtl/gray_pwm_slice.v ====
// one segment pwm comparator with palette code lookup
`timescale 1ns/1ps
module gray_pwm_slice
(
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // pixel and palette
  input  wire [4:0]  pixelCode,
  input  wire [191:0] paletteFlat,
  input  wire [5:0]  pwmPhase,
  input  wire        displayOn,
  // drive
  output reg         segmentOut
);
  reg [4:0] entry;
  wire [5:0] level;

  // fixed code to palette entry map
  always @*
  begin
    case (pixelCode)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
      5'h06, 5'h07, 5'h08, 5'h09, 5'h0a: entry = pixelCode;
      5'h0b: entry = 5'h0c;
      5'h0c: entry = 5'h0e;
      5'h0d: entry = 5'h0f;
      5'h0e: entry = 5'h11;
      5'h0f: entry = 5'h12;
      5'h10: entry = 5'h13;
      5'h11: entry = 5'h15;
      5'h12: entry = 5'h16;
      5'h13: entry = 5'h17;
      5'h14: entry = 5'h18;
      5'h15: entry = 5'h19;
      5'h16: entry = 5'h1a;
      default: entry = pixelCode;
    endcase
  end

  assign level = paletteFlat[entry*6 +: 6];

  // on while phase below level, ground when display off
  always @(posedge clk_sys)
  begin
    if (!rst_n)
      segmentOut <= 1'b0;
    else
      segmentOut <= displayOn & (pwmPhase < level);
  end
endmodule

// ==== rtl/graphics_ram_write_unit.v ====
// graphics ram write datapath with mask, compare, address counter and gray pwm
// Function
// - mask bit 0 writes the ram bit, mask bit 1 keeps stored bit
// - word holds pixels in bits 15:11, 10:6, 4:0; bit 5 unused
// - direction bit and logic code 000/110/111 choose the six write modes
// - horizontal: step +1 or -1, wrap to the next raster row
// - vertical: add 256, past bottom go to next column right or left
// - conditional: byte compare with compare value, 110 match, 111 mismatch
// - write mask applies in every write mode
// - address set loads the counter and the instruction holding register with the same written value
// - counter advances after ram write, holds after ram read
// - 32 palette entries of 6 bits, levels 000000 to 110100
// - pixel code maps to palette entry through a fixed table
// - segment pwm on-time follows the chosen gray level
// - scanned ram word is held in a latch feeding the drivers
// - internal oscillator or external clock mode, frequency set by command
// - display off holds segment and common outputs at ground
// - ram is 162 rows by 132 words, high byte row, low byte word
`timescale 1ns/1ps
`include "gram_write_map.vh"
module graphics_ram_write_unit
#(
  parameter ROWS = 162,
  parameter COLS = 132
)
(
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // display drive
  output wire [2:0]  segment_output,
  output reg         common_output,
  output reg  [15:0] latchedWord,
  // clock mode
  output wire        extClockSelect,
  output wire [3:0]  oscillator_frequency_command
);
  localparam DEPTH = ROWS * 256;

  reg [15:0] display_pixel_ram [0:DEPTH-1];
  reg [15:0] pixel_write_mask;
  reg [15:0] conditional_compare_value;
  reg [5:0]  gray_level_palette_entry [0:31];
  reg [15:0] instruction_holding_register;
  reg [15:0] ram_address_counter;
  reg [15:0] scanAddr;
  reg        write_direction_select;
  reg        stepUp;
  reg [2:0]  logic_operation_code;
  reg        displayOn;
  reg        extClock;
  reg [3:0]  oscCode;
  reg [5:0]  pwmPhase;
  reg [15:0] next_address;
  reg [7:0]  nRow;
  reg [7:0]  nCol;
  wire [191:0] paletteFlat;
  wire       wrAccess;
  wire       rdAccess;
  wire       isPalette;
  wire [4:0] palIdx;
  wire [15:0] ramOld;
  wire [15:0] hostData;
  wire [1:0] byteMatch;
  wire       cond;
  wire [15:0] mergeMask;
  wire [15:0] newWord;
  wire       ramWrite;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wrAccess = psel & penable & pwrite;
  assign rdAccess = psel & penable & ~pwrite;
  assign isPalette = (paddr >= `REG_PALETTE_BASE) && (paddr <= `REG_PALETTE_LAST);
  assign palIdx = paddr[6:2];
  assign extClockSelect = extClock;
  assign oscillator_frequency_command = oscCode;
  assign ramOld = display_pixel_ram[ram_address_counter];
  assign hostData = {pwdata[15:6], 1'b0, pwdata[4:0]};
  assign ramWrite = wrAccess && (paddr == `REG_RAM_DATA);

  // per byte compare against compare value
  assign byteMatch[0] = (hostData[7:0] == conditional_compare_value[7:0]);
  assign byteMatch[1] = (hostData[15:8] == conditional_compare_value[15:8]);
  assign cond = (logic_operation_code == `LOGIC_MATCH) ||
                (logic_operation_code == `LOGIC_MISMATCH);

  // bits that take host data: mask clear and byte condition true
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : gMerge
      wire okByte = ~cond |
        ((logic_operation_code == `LOGIC_MATCH) ? byteMatch[g/8] : ~byteMatch[g/8]);
      assign mergeMask[g] = ~pixel_write_mask[g] & okByte;
      assign newWord[g] = mergeMask[g] ? hostData[g] : ramOld[g];
    end
    for (g = 0; g < 32; g = g + 1)
    begin : gPal
      assign paletteFlat[g*6 +: 6] = gray_level_palette_entry[g];
    end
  endgenerate

  // next address after one ram write
  always @*
  begin
    nRow = ram_address_counter[15:8];
    nCol = ram_address_counter[7:0];
    if (write_direction_select)
    begin
      next_address = ram_address_counter + `VERT_STEP;
      if (nRow >= `ROW_LAST)
      begin
        if (stepUp)
          nCol = (nCol >= `COL_LAST) ? 8'h00 : nCol + 8'h01;
        else
          nCol = (nCol == 8'h00) ? `COL_LAST : nCol - 8'h01;
        next_address = {8'h00, nCol};
      end
    end
    else
    begin
      if (stepUp)
      begin
        if (nCol >= `COL_LAST)
        begin
          nCol = 8'h00;
          nRow = (nRow >= `ROW_LAST) ? 8'h00 : nRow + 8'h01;
        end
        else
          nCol = nCol + 8'h01;
      end
      else
      begin
        if (nCol == 8'h00)
        begin
          nCol = `COL_LAST;
          nRow = (nRow >= `ROW_LAST) ? 8'h00 : nRow + 8'h01;
        end
        else
          nCol = nCol - 8'h01;
      end
      next_address = {nRow, nCol};
    end
  end

  // write a word into the display ram
  always @(posedge clk_sys)
  begin
    if (ramWrite)
      display_pixel_ram[ram_address_counter] <= newWord;
  end

  // control registers and address counter
  integer i;
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pixel_write_mask <= 16'h0000;
      conditional_compare_value <= 16'h0000;
      instruction_holding_register <= 16'h0000;
      ram_address_counter <= 16'h0000;
      write_direction_select <= 1'b0;
      stepUp <= 1'b1;
      logic_operation_code <= `LOGIC_PLAIN;
      displayOn <= 1'b0;
      extClock <= 1'b0;
      oscCode <= 4'h0;
      for (i = 0; i < 32; i = i + 1)
        gray_level_palette_entry[i] <= 6'h00;
    end
    else if (wrAccess)
    begin
      if (isPalette)
        gray_level_palette_entry[palIdx] <= (pwdata[5:0] > `LEVEL_MAX) ?
          `LEVEL_MAX : pwdata[5:0];
      case (paddr)
        `REG_ENTRY_MODE:
        begin
          stepUp <= pwdata[`MODE_STEP_BIT];
          write_direction_select <= pwdata[`MODE_DIR_BIT];
          logic_operation_code <= pwdata[`MODE_LOGIC_HI:`MODE_LOGIC_LO];
        end
        `REG_WRITE_MASK: pixel_write_mask <= pwdata[15:0];
        `REG_COMPARE: conditional_compare_value <= pwdata[15:0];
        `REG_ADDR_SET:
        begin
          instruction_holding_register <= pwdata[15:0];
          ram_address_counter <= pwdata[15:0];
        end
        `REG_RAM_DATA: ram_address_counter <= next_address;
        `REG_DISPLAY_CTRL:
        begin
          displayOn <= pwdata[`CTRL_DISP_ON_BIT];
          extClock <= pwdata[`CTRL_EXT_CLK_BIT];
          oscCode <= pwdata[`CTRL_OSC_HI:`CTRL_OSC_LO];
        end
        default: ;
      endcase
    end
  end

  // register read data, ram read leaves counter alone
  always @(posedge clk_sys)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite)
    begin
      if (isPalette)
        prdata <= {26'h0, gray_level_palette_entry[palIdx]};
      else
        case (paddr)
          `REG_ENTRY_MODE: prdata <= {27'h0, logic_operation_code,
                                      write_direction_select, stepUp};
          `REG_WRITE_MASK: prdata <= {16'h0, pixel_write_mask};
          `REG_COMPARE: prdata <= {16'h0, conditional_compare_value};
          `REG_ADDR_SET: prdata <= {16'h0, instruction_holding_register};
          `REG_RAM_DATA: prdata <= {16'h0, ramOld};
          `REG_ADDR_STATUS: prdata <= {16'h0, ram_address_counter};
          `REG_DISPLAY_CTRL: prdata <= {24'h0, oscCode, 2'b00, extClock, displayOn};
          `REG_SCAN_ADDR: prdata <= {16'h0, scanAddr};
          default: prdata <= 32'h00000000;
        endcase
    end
  end

  // scan: pwm phase counter, latch next word at each period end
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pwmPhase <= 6'h00;
      scanAddr <= 16'h0000;
      latchedWord <= 16'h0000;
      common_output <= 1'b0;
    end
    else
    begin
      common_output <= displayOn & (scanAddr[8] ^ pwmPhase[0]);
      if (pwmPhase >= `PWM_PERIOD - 6'h01)
      begin
        pwmPhase <= 6'h00;
        latchedWord <= display_pixel_ram[scanAddr];
        if (scanAddr[7:0] >= `COL_LAST)
          scanAddr <= (scanAddr[15:8] >= `ROW_LAST) ? 16'h0000 :
                      {scanAddr[15:8] + 8'h01, 8'h00};
        else
          scanAddr <= scanAddr + 16'h0001;
      end
      else
        pwmPhase <= pwmPhase + 6'h01;
    end
  end

  // three segment drivers per latched word
  gray_pwm_slice uSeg0
  (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .pixelCode   (latchedWord[15:11]),
    .paletteFlat (paletteFlat),
    .pwmPhase    (pwmPhase),
    .displayOn   (displayOn),
    .segmentOut  (segment_output[0])
  );
  gray_pwm_slice uSeg1
  (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .pixelCode   (latchedWord[10:6]),
    .paletteFlat (paletteFlat),
    .pwmPhase    (pwmPhase),
    .displayOn   (displayOn),
    .segmentOut  (segment_output[1])
  );
  gray_pwm_slice uSeg2
  (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .pixelCode   (latchedWord[4:0]),
    .paletteFlat (paletteFlat),
    .pwmPhase    (pwmPhase),
    .displayOn   (displayOn),
    .segmentOut  (segment_output[2])
  );
endmodule

// ==== sim/gram_write_checker_assertions.sv ====
// port checker for the graphics ram write unit
`timescale 1ns/1ps
module gram_write_checker
(
  // clock and reset
  input wire        clk_sys,
  input wire        rst_n,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  // display drive and clock mode
  input wire [2:0]  segment_output,
  input wire        common_output,
  input wire [3:0]  oscillator_frequency_command,
  input wire        extClockSelect
);
  wire        rd = psel & penable & ~pwrite;
  wire        wr = psel & penable & pwrite;
  reg         dispOn;
  reg         justSet;
  reg         cntValid;
  reg  [15:0] setAddr;
  reg  [15:0] lastCnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // shadows of display enable, loaded address and last counter read
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      dispOn   <= 1'b0;
      justSet  <= 1'b1;
      setAddr  <= 16'h0000;
      cntValid <= 1'b0;
    end
    else
    begin
      if (wr && paddr == 12'h018) dispOn <= pwdata[0];
      if (wr && paddr == 12'h00c) setAddr <= pwdata[15:0];
      if (wr && (paddr == 12'h00c || paddr == 12'h010)) cntValid <= 1'b0;
      if (wr && (paddr == 12'h00c || paddr == 12'h010)) justSet <= (paddr == 12'h00c);
      if (rd && paddr == 12'h014) cntValid <= 1'b1;
      if (rd && paddr == 12'h014) lastCnt <= prdata[15:0];
    end
  end
  a_ready_high: assert property (pready) else $error("pready low");
  a_no_error: assert property (!pslverr) else $error("pslverr raised");
  a_dark_off: assert property (!dispOn && !$past(dispOn) && !$past(dispOn, 2) |->
    segment_output == 3'h0 && !common_output) else $error("drive while display off");
  a_clock_mode: assert property (wr && paddr == 12'h018 |=> extClockSelect == $past(pwdata[1])
    && oscillator_frequency_command == $past(pwdata[7:4])) else $error("clock mode bits");
  a_level_limit: assert property (rd && paddr >= 12'h100 && paddr <= 12'h17c
    |-> prdata <= 32'h0000_0034) else $error("gray level above limit");
  a_unmapped_zero: assert property (rd && ((paddr >= 12'h020 && paddr < 12'h100) || paddr > 12'h17c)
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  a_addr_load: assert property (rd && paddr == 12'h014 && justSet
    |-> prdata[15:0] == setAddr) else $error("counter not loaded");
  a_read_hold: assert property (rd && paddr == 12'h014 && cntValid
    |-> prdata[15:0] == lastCnt) else $error("counter moved without write");
endmodule
bind graphics_ram_write_unit gram_write_checker gram_write_checker_i
  (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .segment_output(segment_output), .common_output(common_output),
   .oscillator_frequency_command(oscillator_frequency_command),
   .extClockSelect(extClockSelect));

// ==== sim/host_apb_master.sv ====
// host side apb master model
`timescale 1ns/1ps
module host_apb_master
(
  // clock
  input  wire        clk_sys,
  // request
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [11:0] paddr,
  output reg  [31:0] pwdata,
  // answer
  input  wire        pready,
  input  wire [31:0] prdata
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end
  // setup, access until pready at an edge, then release
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    begin
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= (a == 12'h010) ? (d & ~32'h20) : d; // pixel word spare bit kept clear
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      r = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~pwdata; // released data does not look stale
      @(posedge clk_sys);
    end
  endtask
endmodule

// ==== sim/tb_graphics_ram_write_unit.sv ====
// self-checking bench for the graphics ram write unit
`timescale 1ns/1ps
module tb_graphics_ram_write_unit;
  logic        clk_sys;
  logic        rst_n;
  wire         psel, penable, pwrite, pready, pslverr, common_output, extClockSelect;
  wire  [11:0] paddr;
  wire  [31:0] pwdata, prdata;
  wire  [2:0]  segment_output;
  wire  [15:0] latchedWord;
  wire  [3:0]  oscillator_frequency_command;
  logic [31:0] rdat;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  localparam logic [4:0]  MD [0:6] = '{5'h01, 5'h00, 5'h03, 5'h03, 5'h02, 5'h19, 5'h1f};
  localparam logic [15:0] ST [0:6] = '{16'h0083, 16'h0005, 16'ha105, 16'h0005, 16'ha105,
                                       16'h0010, 16'h0010};
  localparam logic [15:0] NX [0:6] = '{16'h0100, 16'h0004, 16'h0006, 16'h0105, 16'h0004,
                                       16'h0011, 16'h0110};
  graphics_ram_write_unit graphics_ram_write_unit_i
    (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
     .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
     .segment_output(segment_output), .common_output(common_output),
     .latchedWord(latchedWord), .extClockSelect(extClockSelect),
     .oscillator_frequency_command(oscillator_frequency_command));
  host_apb_master host_apb_master_i
    (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
     .pwdata(pwdata), .pready(pready), .prdata(prdata));
  // clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // hang guard
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    host_apb_master_i.xfer(1'b1, a, d, rdat);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    host_apb_master_i.xfer(1'b0, a, 32'h0, rdat);
    check(rdat, e);
  endtask
  task test_reset;
    rdc(12'h000, 32'h1);
    rdc(12'h004, 32'h0);
    rdc(12'h008, 32'h0);
    rdc(12'h014, 32'h0);
    wr(12'h020, 32'hffff_ffff);
    rdc(12'h020, 32'h0);
  endtask
  task test_mask;
    wr(12'h004, 32'h0);
    wr(12'h00c, 32'h0);
    wr(12'h010, 32'h0);
    wr(12'h004, 32'h07ff);
    wr(12'h00c, 32'h0);
    wr(12'h010, 32'hffdf);
    rdc(12'h014, 32'h1);
    wr(12'h00c, 32'h0);
    rdc(12'h014, 32'h0);
    rdc(12'h010, 32'hf800);
    rdc(12'h014, 32'h0);
  endtask
  task test_step;
    wr(12'h004, 32'hffff);
    for (int i = 0; i < 7; i++)
    begin
      wr(12'h000, {27'h0, MD[i]});
      wr(12'h00c, {16'h0, ST[i]});
      wr(12'h010, 32'h0);
      rdc(12'h014, {16'h0, NX[i]});
    end
  endtask
  task test_cond;
    wr(12'h004, 32'h0);
    wr(12'h008, 32'h2840);
    wr(12'h000, 32'h01);
    wr(12'h00c, 32'h10);
    wr(12'h010, 32'h0);
    wr(12'h000, 32'h19);
    wr(12'h00c, 32'h10);
    wr(12'h010, 32'h28ff);
    wr(12'h00c, 32'h10);
    rdc(12'h010, 32'h2800);
    wr(12'h000, 32'h1d);
    wr(12'h00c, 32'h10);
    wr(12'h010, 32'h1140);
    wr(12'h00c, 32'h10);
    rdc(12'h010, 32'h1100);
    wr(12'h004, 32'hff00);
    wr(12'h00c, 32'h10);
    wr(12'h010, 32'h5511);
    wr(12'h00c, 32'h10);
    rdc(12'h010, 32'h1111);
  endtask
  // word planted ahead of the scan, then latch and pwm on-times counted
  task test_scan;
    logic [15:0] s;
    logic [15:0] t;
    int          on0;
    int          on1;
    int          on2;
    on0 = 0;
    on1 = 0;
    on2 = 0;
    wr(12'h000, 32'h01);
    wr(12'h004, 32'h0);
    wr(12'h130, 32'h15);
    wr(12'h168, 32'h30);
    wr(12'h114, 32'h07);
    wr(12'h018, 32'h1);
    host_apb_master_i.xfer(1'b0, 12'h01c, 32'h0, rdat);
    s = rdat[15:0];
    if (s[7:0] >= 8'h83)
      t = (s[15:8] >= 8'ha1) ? 16'h0000 : {s[15:8] + 8'h01, 8'h00};
    else
      t = s + 16'h0001;
    wr(12'h00c, {16'h0, t});
    wr(12'h010, 32'h5d85);
    for (int k = 0; k < 160 && latchedWord !== 16'h5d85; k++)
    begin
      @(posedge clk_sys);
      #1;
    end
    check({16'h0, latchedWord}, 32'h5d85);
    repeat (52)
    begin
      @(posedge clk_sys);
      #1;
      on0 += segment_output[0];
      on1 += segment_output[1];
      on2 += segment_output[2];
    end
    check(on0, 32'd21);
    check(on1, 32'd48);
    check(on2, 32'd7);
    @(posedge clk_sys);
  endtask
  task test_pal_disp;
    wr(12'h100, 32'h3f);
    rdc(12'h100, 32'h34);
    wr(12'h17c, 32'h2a);
    rdc(12'h17c, 32'h2a);
    wr(12'h018, 32'ha3);
    check({28'h0, oscillator_frequency_command}, 32'ha);
    check({31'h0, extClockSelect}, 32'h1);
    wr(12'h018, 32'h0);
    repeat (3) @(posedge clk_sys);
    #1 check({28'h0, common_output, segment_output}, 32'h0);
  endtask
  task wrap_up;
    $display("err_total=%0d samples_checked=%0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // reset then scenarios
  initial
  begin
    rst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    test_reset();
    test_mask();
    test_step();
    test_cond();
    test_scan();
    test_pal_disp();
    wrap_up();
  end
endmodule
